//--- pkg/remap_cmd_params.svh
// offsets, field positions, reset values and timing counts of the command block
`ifndef REMAP_CMD_PARAMS_SVH
`define REMAP_CMD_PARAMS_SVH

// register offsets (byte addresses)
`define GLOBAL_COMMAND_OFS 8'h18
`define GLOBAL_STATUS_OFS 8'h1C
`define FEATURE_CFG_OFS 8'h40
`define INTR_TABLE_ADDRESS_OFS 8'h44
`define TABLE_POINTER_OFS 8'h48

// command and status bit positions
`define ADV_FAULT_LOG_BIT 28
`define WRITE_BUFFER_FLUSH_BIT 27
`define QUEUED_INVAL_BIT 26
`define INTR_REMAP_BIT 25
`define INTR_TABLE_POINTER_BIT 24

// feature configuration bit positions
`define FEAT_AFL_BIT 0
`define FEAT_WBF_BIT 1
`define FEAT_QI_BIT 2
`define FEAT_IR_BIT 3

// reset values (FEATURE_CFG_RST is not applied; the feature word resets to zero)
`define FEATURE_CFG_RST 4'hF
`define INTR_TABLE_ADDRESS_RST 32'h0000_0000

// timing: write buffer flush settle time in ns, converted at 100 MHz
`define CLK_PERIOD_NS 10
`define FLUSH_TIME_NS 40
`define FLUSH_CYCLES ((`FLUSH_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

//--- pkg/remap_cmd_pkg.sv
// types shared by the command block modules
package remap_cmd_pkg;

   typedef enum logic [1:0] {
      IR_OFF,
      IR_DRAIN_ON,
      IR_ON,
      IR_DRAIN_OFF
   } ir_state_type;

   typedef enum logic [1:0] {
      FL_IDLE,
      FL_WAIT,
      FL_SETTLE
   } flush_state_type;

endpackage

//--- pkg/flush_if.sv
// request and done handshake between the command block and its flush engine
`timescale 1ns/1ps
interface flush_if;
   logic req;
   logic busy;
   logic done;

   modport requester (
      output req,
      input busy,
      input done
   );

   modport engine (
      input req,
      output busy,
      output done
   );
endinterface

//--- rtl/write_flush_engine.sv
// write posting buffer flush sequencer
`timescale 1ns/1ps
`include "remap_cmd_params.svh"
module write_flush_engine #(
   parameter int FLUSH_CYCLES = `FLUSH_CYCLES
) (
   // clock and reset
   input wire logic clk_sys,
   input wire logic rstn,
   // request side
   flush_if.engine fl,
   // posting buffer
   output logic wbuf_drain_req,
   input wire logic wbuf_empty
);

   remap_cmd_pkg::flush_state_type state_q;
   logic [7:0] cnt_q;
   logic done_q;

   // ----------------------------------------
   // flush sequence
   // ----------------------------------------
   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         state_q <= remap_cmd_pkg::FL_IDLE;
         cnt_q <= 8'h00;
         done_q <= 1'b0;
      end else begin
         done_q <= 1'b0;
         case (state_q)
            remap_cmd_pkg::FL_IDLE: begin
               if (fl.req) begin
                  state_q <= remap_cmd_pkg::FL_WAIT;
               end
            end
            remap_cmd_pkg::FL_WAIT: begin
               if (wbuf_empty) begin
                  state_q <= remap_cmd_pkg::FL_SETTLE;
                  cnt_q <= 8'(FLUSH_CYCLES);
               end
            end
            remap_cmd_pkg::FL_SETTLE: begin
               // lets the last posted write reach memory before reporting
               if (cnt_q <= 8'h01) begin
                  state_q <= remap_cmd_pkg::FL_IDLE;
                  done_q <= 1'b1;
               end else begin
                  cnt_q <= cnt_q - 8'h01;
               end
            end
            default: begin
               state_q <= remap_cmd_pkg::FL_IDLE;
            end
         endcase
      end
   end

   assign wbuf_drain_req = (state_q == remap_cmd_pkg::FL_WAIT);
   assign fl.busy = (state_q != remap_cmd_pkg::FL_IDLE);
   assign fl.done = done_q;

endmodule

//--- rtl/remap_global_command_upper.sv
// global command bits 28 to 24 with their status reporting
//
// Design decisions made here: the plain strobed port and the register offsets.
`timescale 1ns/1ps
`include "remap_cmd_params.svh"
module remap_global_command_upper #(
   parameter int FLUSH_CYCLES = `FLUSH_CYCLES,
   parameter logic [3:0] FEATURE_RST = `FEATURE_CFG_RST
) (
   // clock and reset
   input wire logic clk_sys,
   input wire logic rstn,
   // register port
   input wire logic [7:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [31:0] reg_rdata,
   // fault logging path
   output logic fault_log_to_memory,
   // queued invalidation
   output logic queued_inval_active,
   // interrupt remapping datapath
   output logic intr_remap_active,
   output logic intr_accept_hold,
   input wire logic intr_in_flight,
   input wire logic intr_queue_empty,
   output logic [31:0] intr_table_pointer,
   // invalidation requests from the cache logic
   input wire logic cache_inval_req,
   output logic cache_inval_go,
   // write posting buffer
   output logic wbuf_drain_req,
   input wire logic wbuf_empty
);

   flush_if fl ();

   logic [3:0] feature_q;
   logic [31:0] table_address_q;
   logic [31:0] table_pointer_q;
   logic afl_status_q;
   logic qi_status_q;
   logic ir_status_q;
   logic itp_status_q;
   logic wbf_status_q;
   logic flush_req_q;
   logic inval_pending_q;
   logic inval_go_q;
   logic [1:0] itp_pend_q;
   remap_cmd_pkg::ir_state_type ir_state_q;
   logic cmd_wr;
   logic feat_afl;
   logic feat_wbf;
   logic feat_qi;
   logic feat_ir;

   function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
      hit = (a == ofs);
   endfunction

   // ----------------------------------------
   // decode
   // ----------------------------------------
   assign cmd_wr = reg_wr && hit(reg_addr, `GLOBAL_COMMAND_OFS);
   assign feat_afl = feature_q[`FEAT_AFL_BIT];
   assign feat_wbf = feature_q[`FEAT_WBF_BIT];
   assign feat_qi = feature_q[`FEAT_QI_BIT];
   assign feat_ir = feature_q[`FEAT_IR_BIT];

   // ----------------------------------------
   // configuration registers
   // ----------------------------------------
   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         feature_q <= 4'h0;
      end else if (reg_wr && hit(reg_addr, `FEATURE_CFG_OFS)) begin
         feature_q <= reg_wdata[3:0];
      end
   end

   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         table_address_q <= `INTR_TABLE_ADDRESS_RST;
      end else if (reg_wr && hit(reg_addr, `INTR_TABLE_ADDRESS_OFS)) begin
         table_address_q <= reg_wdata;
      end
   end

   // ----------------------------------------
   // advanced fault logging
   // ----------------------------------------
   // pointer loading is the software's duty; no check here
   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         afl_status_q <= 1'b0;
      end else if (cmd_wr && feat_afl) begin
         afl_status_q <= reg_wdata[`ADV_FAULT_LOG_BIT];
      end
   end
   assign fault_log_to_memory = afl_status_q;

   // ----------------------------------------
   // queued invalidation
   // ----------------------------------------
   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         qi_status_q <= 1'b0;
      end else if (cmd_wr && feat_qi) begin
         qi_status_q <= reg_wdata[`QUEUED_INVAL_BIT];
      end
   end
   assign queued_inval_active = qi_status_q;

   // ----------------------------------------
   // write buffer flush
   // ----------------------------------------
   logic flush_cmd;
   assign flush_cmd = cmd_wr && feat_wbf && reg_wdata[`WRITE_BUFFER_FLUSH_BIT];

   logic flush_new;
   logic flush_issue;
   logic flush_want_q;
   logic flush_final;
   assign flush_new = flush_cmd || (cache_inval_req && feat_wbf && !inval_pending_q);
   assign flush_issue = (flush_new || flush_want_q) && !fl.busy && !flush_req_q;

   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         flush_req_q <= 1'b0;
      end else begin
         // one request per command or per held invalidation
         flush_req_q <= flush_issue;
      end
   end

   // a request that meets a running flush is kept and runs next, never dropped
   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         flush_want_q <= 1'b0;
      end else if (flush_issue) begin
         flush_want_q <= 1'b0;
      end else if (flush_new) begin
         flush_want_q <= 1'b1;
      end
   end

   // only the last flush of a run reports completion
   assign flush_final = fl.done && !flush_want_q && !flush_req_q;
   assign fl.req = flush_req_q;

   // status stays set from command until the flush has fully finished
   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         wbf_status_q <= 1'b0;
      end else if (flush_cmd) begin
         wbf_status_q <= 1'b1;
      end else if (flush_final) begin
         wbf_status_q <= 1'b0;
      end
   end

   // invalidations wait for an implicit flush when flushing is required
   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         inval_pending_q <= 1'b0;
         inval_go_q <= 1'b0;
      end else begin
         inval_go_q <= 1'b0;
         if (cache_inval_req && !feat_wbf && !inval_pending_q) begin
            inval_go_q <= 1'b1;
         end else if (cache_inval_req && feat_wbf && !inval_pending_q) begin
            inval_pending_q <= 1'b1;
         end else if (inval_pending_q && flush_final) begin
            inval_pending_q <= 1'b0;
            inval_go_q <= 1'b1;
         end
      end
   end
   assign cache_inval_go = inval_go_q;

   write_flush_engine #(
      .FLUSH_CYCLES(FLUSH_CYCLES)
   ) u_flush (
      .clk_sys(clk_sys),
      .rstn(rstn),
      .fl(fl),
      .wbuf_drain_req(wbuf_drain_req),
      .wbuf_empty(wbuf_empty)
   );

   // ----------------------------------------
   // interrupt table pointer
   // ----------------------------------------
   // status cleared on command, set two cycles later once the pointer is live
   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         itp_pend_q <= 2'b00;
         itp_status_q <= 1'b0;
         table_pointer_q <= 32'h0000_0000;
      end else begin
         itp_pend_q <= {itp_pend_q[0], 1'b0};
         if (cmd_wr && feat_ir && reg_wdata[`INTR_TABLE_POINTER_BIT]) begin
            itp_pend_q <= 2'b01;
            itp_status_q <= 1'b0;
         end else if (itp_pend_q[1]) begin
            // load only between interrupts so none sees a half-old pointer
            if (!intr_in_flight) begin
               table_pointer_q <= table_address_q;
               itp_status_q <= 1'b1;
            end else begin
               itp_pend_q <= 2'b10;
            end
         end
      end
   end
   assign intr_table_pointer = table_pointer_q;

   // ----------------------------------------
   // interrupt remapping enable
   // ----------------------------------------
   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         ir_state_q <= remap_cmd_pkg::IR_OFF;
      end else begin
         case (ir_state_q)
            remap_cmd_pkg::IR_OFF: begin
               if (cmd_wr && feat_ir && reg_wdata[`INTR_REMAP_BIT]) begin
                  ir_state_q <= remap_cmd_pkg::IR_DRAIN_ON;
               end
            end
            remap_cmd_pkg::IR_DRAIN_ON: begin
               if (intr_queue_empty && !intr_in_flight) begin
                  ir_state_q <= remap_cmd_pkg::IR_ON;
               end
            end
            remap_cmd_pkg::IR_ON: begin
               if (cmd_wr && feat_ir && !reg_wdata[`INTR_REMAP_BIT]) begin
                  ir_state_q <= remap_cmd_pkg::IR_DRAIN_OFF;
               end
            end
            remap_cmd_pkg::IR_DRAIN_OFF: begin
               if (!intr_in_flight) begin
                  ir_state_q <= remap_cmd_pkg::IR_OFF;
               end
            end
            default: begin
               ir_state_q <= remap_cmd_pkg::IR_OFF;
            end
         endcase
      end
   end

   // status follows only the completed states
   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         ir_status_q <= 1'b0;
      end else begin
         ir_status_q <= (ir_state_q == remap_cmd_pkg::IR_ON)
            || (ir_state_q == remap_cmd_pkg::IR_DRAIN_OFF);
      end
   end

   // new interrupts held off while a switch is pending
   assign intr_accept_hold = (ir_state_q == remap_cmd_pkg::IR_DRAIN_ON)
      || (ir_state_q == remap_cmd_pkg::IR_DRAIN_OFF);
   assign intr_remap_active = (ir_state_q == remap_cmd_pkg::IR_ON)
      || (ir_state_q == remap_cmd_pkg::IR_DRAIN_OFF);

   // ----------------------------------------
   // read back
   // ----------------------------------------
   logic [31:0] status_word;
   always_comb begin
      status_word = 32'h0000_0000;
      status_word[`ADV_FAULT_LOG_BIT] = afl_status_q;
      status_word[`WRITE_BUFFER_FLUSH_BIT] = wbf_status_q;
      status_word[`QUEUED_INVAL_BIT] = qi_status_q;
      status_word[`INTR_REMAP_BIT] = ir_status_q;
      status_word[`INTR_TABLE_POINTER_BIT] = itp_status_q;
   end

   // address decode of the readable words
   function automatic logic [31:0] read_word(input logic [7:0] a, input logic [31:0] sts,
         input logic [3:0] feat, input logic [31:0] tad, input logic [31:0] tpt);
      case (a)
         `GLOBAL_STATUS_OFS: begin
            read_word = sts;
         end
         `FEATURE_CFG_OFS: begin
            read_word = {28'h000_0000, feat};
         end
         `INTR_TABLE_ADDRESS_OFS: begin
            read_word = tad;
         end
         `TABLE_POINTER_OFS: begin
            read_word = tpt;
         end
         default: begin
            // command register is write only and reads zero, as do holes
            read_word = 32'h0000_0000;
         end
      endcase
   endfunction

   // data stand one cycle only, so a stale word never looks like an answer
   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         reg_rdata <= 32'h0000_0000;
      end else if (reg_rd) begin
         reg_rdata <= read_word(reg_addr, status_word, feature_q, table_address_q,
            table_pointer_q);
      end else begin
         reg_rdata <= 32'h0000_0000;
      end
   end

   // FEATURE_RST is not applied; the feature word resets to zero, all features off
   logic unused_feat_rst;
   assign unused_feat_rst = ^FEATURE_RST;

endmodule

//--- dv/remap_global_command_upper_monitor.sv
// port level checker of the upper global command bits
`timescale 1ns/1ps
module remap_global_command_upper_monitor #(
   parameter int FLUSH_CYCLES = 4
) (
   // clock and reset
   input wire logic clk_sys,
   input wire logic rstn,
   // register port
   input wire logic [7:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [31:0] reg_rdata,
   // datapath
   input wire logic fault_log_to_memory,
   input wire logic queued_inval_active,
   input wire logic intr_remap_active,
   input wire logic intr_in_flight,
   input wire logic intr_queue_empty,
   input wire logic cache_inval_go,
   input wire logic wbuf_drain_req
);
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!rstn);
   // ----
   // feature shadow
   // ----
   // mirrors the feature word so gated commands can be told apart
   logic [3:0] feat_q;
   logic cmd_wr;
   assign cmd_wr = reg_wr && reg_addr == 8'h18;
   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn)
         feat_q <= 4'h0;
      else if (reg_wr && reg_addr == 8'h40)
         feat_q <= reg_wdata[3:0];
   end
   // ----
   // properties
   // ----
   rdata_idle_a: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0)
      else $error("read data not zero outside a read");
   cmd_read_a: assert property (reg_rd && reg_addr == 8'h18 |=> reg_rdata == 32'h0)
      else $error("command word read back a value");
   afl_follow_a: assert property (cmd_wr && feat_q[0]
      |=> fault_log_to_memory == $past(reg_wdata[28]))
      else $error("fault log path did not follow command");
   afl_gated_a: assert property (cmd_wr && !feat_q[0] |=> $stable(fault_log_to_memory))
      else $error("fault log changed with feature off");
   qi_follow_a: assert property (cmd_wr && feat_q[2]
      |=> queued_inval_active == $past(reg_wdata[26]))
      else $error("queued invalidation did not follow command");
   flush_start_a: assert property (cmd_wr && feat_q[1] && reg_wdata[27] && !wbuf_drain_req
      |-> ##2 wbuf_drain_req)
      else $error("flush command did not drain buffer");
   flush_zero_a: assert property (cmd_wr && !reg_wdata[27] && !wbuf_drain_req
      |=> !wbuf_drain_req)
      else $error("zero flush bit started a drain");
   remap_on_a: assert property ($rose(intr_remap_active)
      |-> $past(intr_queue_empty) && !$past(intr_in_flight))
      else $error("remap enabled before drain");
   remap_off_a: assert property ($fell(intr_remap_active) |-> !$past(intr_in_flight))
      else $error("remap disabled mid transaction");
   go_after_flush_a: assert property (cache_inval_go
      |-> !wbuf_drain_req ##1 !cache_inval_go)
      else $error("invalidation released during drain");
   cover property ($rose(intr_remap_active));
   cover property ($rose(wbuf_drain_req));
   cover property (cache_inval_go);
endmodule

bind remap_global_command_upper remap_global_command_upper_monitor #(
   .FLUSH_CYCLES(FLUSH_CYCLES)
) u_remap_global_command_upper_monitor (
   .clk_sys(clk_sys), .rstn(rstn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
   .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
   .fault_log_to_memory(fault_log_to_memory), .queued_inval_active(queued_inval_active),
   .intr_remap_active(intr_remap_active), .intr_in_flight(intr_in_flight),
   .intr_queue_empty(intr_queue_empty), .cache_inval_go(cache_inval_go),
   .wbuf_drain_req(wbuf_drain_req)
);

//--- dv/remap_global_command_upper_tb.sv
// self-checking bench of the upper global command bits
`timescale 1ns/1ps
`define CHK(n, e, g) begin cmp_count++; if ((g) !== (e)) begin miscompares++; \
   $display("BAD %s exp %0h got %0h", n, e, g); end end
module remap_global_command_upper_tb;
   localparam int FC = 4;
   logic clk_sys = 1'b0;
   logic rstn = 1'b0;
   logic [7:0] reg_addr = 8'h00;
   logic [31:0] reg_wdata = 32'h0;
   logic reg_wr = 1'b0, reg_rd = 1'b0, intr_in_flight = 1'b0, intr_queue_empty = 1'b1;
   logic cache_inval_req = 1'b0, wbuf_empty = 1'b1;
   logic [31:0] reg_rdata, intr_table_pointer, s, ta;
   logic fault_log_to_memory, queued_inval_active, intr_remap_active, intr_accept_hold;
   logic cache_inval_go, wbuf_drain_req;
   int miscompares = 0, cmp_count = 0, afl = 0, qi = 0, ir = 0, n;
   bit seen;
   always #5 clk_sys = ~clk_sys;
   remap_global_command_upper #(.FLUSH_CYCLES(FC)) u_remap_global_command_upper (
      .clk_sys(clk_sys), .rstn(rstn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .fault_log_to_memory(fault_log_to_memory), .queued_inval_active(queued_inval_active),
      .intr_remap_active(intr_remap_active), .intr_accept_hold(intr_accept_hold),
      .intr_in_flight(intr_in_flight), .intr_queue_empty(intr_queue_empty),
      .intr_table_pointer(intr_table_pointer), .cache_inval_req(cache_inval_req),
      .cache_inval_go(cache_inval_go), .wbuf_drain_req(wbuf_drain_req), .wbuf_empty(wbuf_empty)
   );
   // ----
   // bus tasks
   // ----
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk_sys);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge clk_sys);
      reg_wr <= 1'b0;
   endtask
   // data is looked at mid cycle, where the single valid cycle is settled
   task automatic rd(input logic [7:0] a, output logic [31:0] d);
      @(posedge clk_sys);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge clk_sys);
      reg_rd <= 1'b0;
      @(negedge clk_sys);
      d = reg_rdata;
   endtask
   task automatic cyc(input int k);
      repeat (k) @(negedge clk_sys);
   endtask
   function automatic logic [31:0] cmd(input bit write_buffer_flush_cmd, input bit ptr);
      return {3'h0, afl[0], write_buffer_flush_cmd, qi[0], ir[0], ptr, 24'h0};
   endfunction
   task automatic complete_run;
      $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
      if (miscompares == 0 && cmp_count > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask
   // ----
   // scenarios
   // ----
   initial begin
      #100000;
      miscompares++;
      complete_run;
   end
   initial begin
      void'($urandom(39739));
      repeat (16) @(posedge clk_sys);
      rstn <= 1'b1;
      rd(8'h1C, s);
      `CHK("status reset", 32'h0, s)
      rd(8'h18, s);
      `CHK("command read", 32'h0, s)
      rd(8'h7C, s);
      `CHK("unmapped read", 32'h0, s)
      // features are off after reset, so every command must be ignored
      wr(8'h18, 32'h1F00_0000);
      rd(8'h1C, s);
      `CHK("gated status", 5'h00, s[28:24])
      `CHK("gated drain", 1'b0, wbuf_drain_req)
      wr(8'h40, 32'h0000_000F);
      rd(8'h40, s);
      `CHK("feature word", 4'hF, s[3:0])
      for (int i = 0; i < 8; i++) begin
         afl = $urandom_range(1);
         qi = $urandom_range(1);
         wr(8'h18, cmd(0, 0));
         rd(8'h1C, s);
         `CHK("to memory", afl[0], fault_log_to_memory)
         `CHK("fault log status", afl[0], s[28])
         `CHK("queued active", qi[0], queued_inval_active)
         `CHK("queued status", qi[0], s[26])
      end
      wbuf_empty <= 1'b0;
      wr(8'h18, cmd(1, 0));
      rd(8'h1C, s);
      `CHK("flush busy", 1'b1, s[27])
      `CHK("drain", 1'b1, wbuf_drain_req)
      cyc(6);
      rd(8'h1C, s);
      `CHK("flush held", 1'b1, s[27])
      wbuf_empty <= 1'b1;
      n = 0;
      do begin
         rd(8'h1C, s);
         n++;
      end while (s[27] && n < 20);
      `CHK("flush done", 1'b0, s[27])
      `CHK("settle", 1'b1, n > 1)
      wr(8'h18, cmd(0, 0));
      rd(8'h1C, s);
      `CHK("no flush", 1'b0, wbuf_drain_req | s[27])
      ta = $urandom;
      wr(8'h44, ta);
      intr_in_flight <= 1'b1;
      wr(8'h18, cmd(0, 1));
      rd(8'h1C, s);
      `CHK("pointer status", 1'b0, s[24])
      cyc(4);
      `CHK("pointer held", 32'h0, intr_table_pointer)
      intr_in_flight <= 1'b0;
      cyc(4);
      `CHK("pointer", ta, intr_table_pointer)
      wr(8'h18, cmd(0, 0));
      rd(8'h1C, s);
      `CHK("pointer set", 1'b1, s[24])
      rd(8'h48, s);
      `CHK("pointer read", ta, s)
      intr_queue_empty <= 1'b0;
      ir = 1;
      wr(8'h18, cmd(0, 0));
      cyc(3);
      `CHK("drain hold", 1'b1, intr_accept_hold)
      rd(8'h1C, s);
      `CHK("remap early", 2'b00, {intr_remap_active, s[25]})
      intr_queue_empty <= 1'b1;
      n = 0;
      while (intr_remap_active !== 1'b1 && n < 20) begin
         cyc(1);
         n++;
      end
      rd(8'h1C, s);
      `CHK("remap on", 2'b11, {intr_remap_active, s[25]})
      intr_in_flight <= 1'b1;
      ir = 0;
      wr(8'h18, cmd(0, 0));
      cyc(3);
      `CHK("remap kept", 1'b1, intr_remap_active)
      intr_in_flight <= 1'b0;
      cyc(4);
      rd(8'h1C, s);
      `CHK("remap off", 2'b00, {intr_remap_active, s[25]})
      seen = 1'b0;
      @(posedge clk_sys);
      cache_inval_req <= 1'b1;
      @(posedge clk_sys);
      cache_inval_req <= 1'b0;
      n = 0;
      while (cache_inval_go !== 1'b1 && n < 30) begin
         cyc(1);
         seen |= wbuf_drain_req;
         n++;
      end
      `CHK("go after flush", 2'b11, {cache_inval_go, seen})
      wr(8'h40, 32'h0000_000D);
      @(posedge clk_sys);
      cache_inval_req <= 1'b1;
      @(posedge clk_sys);
      cache_inval_req <= 1'b0;
      cyc(1);
      `CHK("direct go", 1'b1, cache_inval_go)
      cyc(1);
      `CHK("go pulse", 1'b0, cache_inval_go)
      complete_run;
   end
endmodule
